/* File: srss_host_model.sv */
// Host controller model: register reads and writes and state commands
`timescale 1ns/1ps
module srss_host_model
    import srss_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic [7:0] rdata_in, // Register read data
    input wire logic rvalid_in, // Read data valid pulse
    output logic rd_out, // Register read strobe
    output logic wr_out, // Register write strobe
    output logic [1:0] sel_out, // Register selector
    output logic [7:0] wdata_out, // Register write data
    output srss_cmd_t cmd_out, // Command pulse
    output logic [SLOT_AW-1:0] slot_out // Slot index
);
    // Idle bus at time zero
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        sel_out = 2'h0;
        wdata_out = 8'h00;
        cmd_out = SRSS_CMD_NONE;
        slot_out = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle read strobe; data and valid land at the edge that takes it
    task automatic reg_read(input logic [1:0] sel, output logic [7:0] data, output logic ok);
        @(posedge clk_in);
        rd_out <= 1'b1;
        sel_out <= sel;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1;
        ok = rvalid_in;
        data = rdata_in;
    endtask : reg_read

    // Mask writes: a one enables the matching event or status bit
    task automatic reg_write(input logic [1:0] sel, input logic [7:0] data);
        @(posedge clk_in);
        wr_out <= 1'b1;
        sel_out <= sel;
        wdata_out <= data;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask : reg_write

    ////////////////////////////////////////////////////////////////////////////
    // Command pulse; returns just after the edge that takes it
    task automatic command(input srss_cmd_t cmd, input logic [SLOT_AW-1:0] slot);
        @(posedge clk_in);
        cmd_out <= cmd;
        slot_out <= slot;
        @(posedge clk_in);
        cmd_out <= SRSS_CMD_NONE;
        slot_out <= ~slot; // Stale index must not matter once taken
        #1;
    endtask : command
endmodule : srss_host_model

/* File: srss_pkg.sv */
// Shared constants and carrier types for the status and state store block
package srss_pkg;
    // Standard event latch bit positions
    localparam int unsigned EVT_DONE_BIT = 0;
    localparam int unsigned EVT_QUERY_BIT = 2;
    localparam int unsigned EVT_DEVICE_BIT = 3;
    localparam int unsigned EVT_EXEC_BIT = 4;
    localparam int unsigned EVT_CMD_BIT = 5;
    localparam int unsigned EVT_POWER_BIT = 7;
    localparam logic [7:0] EVT_USED_MASK = 8'h00_BD;
    // Status byte bit positions
    localparam int unsigned STB_MSG_BIT = 4;
    localparam int unsigned STB_ESUM_BIT = 5;
    localparam int unsigned STB_SSUM_BIT = 6;
    localparam logic [7:0] SVC_USED_MASK = 8'h00_30;
    // Register selectors on the command port
    localparam logic [1:0] REG_EVENT_LATCH = 2'h0;
    localparam logic [1:0] REG_EVENT_ENABLE = 2'h1;
    localparam logic [1:0] REG_STATUS_BYTE = 2'h2;
    localparam logic [1:0] REG_SERVICE_ENABLE = 2'h3;
    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00_00;
    // Store geometry
    localparam int unsigned SLOT_COUNT = 100;
    localparam int unsigned SLOT_AW = 7;
    localparam int unsigned PARAM_W = 16;
    // Protection level default numerator and denominator: 110 percent
    localparam int unsigned PROT_PCT = 110;
    localparam int unsigned PCT_DIV = 100;

    // Five stored parameters of one slot
    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] volt_prot;
        logic [15:0] curr_prot;
        logic [15:0] timed_run;
    } srss_setpts_t;

    // Commands from the parser
    typedef enum logic [2:0] {
        SRSS_CMD_NONE,
        SRSS_CMD_STORE,
        SRSS_CMD_RESTORE,
        SRSS_CMD_FACTORY,
        SRSS_CMD_CLEAR,
        SRSS_CMD_ABORT
    } srss_cmd_t;
endpackage : srss_pkg

/* File: srss_slot_mem.sv */
// Slot memory holding saved setpoint sets, registered read data
`timescale 1ns/1ps
module srss_slot_mem
    import srss_pkg::*;
#(
    parameter int unsigned DEPTH = SLOT_COUNT,
    parameter int unsigned AW = SLOT_AW
) (
    input wire logic clk_in, // Clock
    input wire logic wr_en_in, // Write strobe
    input wire logic [AW-1:0] addr_in, // Slot index
    input wire srss_setpts_t wr_data_in, // Data to store
    output srss_setpts_t rd_data_out // Registered read data
);
    srss_setpts_t mem [DEPTH];

    // Write port and read register; contents undefined until stored
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[addr_in];
    end
endmodule : srss_slot_mem

/* File: srss_status_regs.sv */
// Event latch, both enable masks and the status byte composition
`timescale 1ns/1ps
module srss_status_regs
    import srss_pkg::*;
(
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Sync reset, high
    input wire logic [7:0] event_set_in, // Event pulses, latch layout
    input wire logic clear_in, // Clear status pulse
    input wire logic latch_read_in, // Event latch read pulse
    input wire logic eve_wr_in, // Event enable write
    input wire logic sve_wr_in, // Service enable write
    input wire logic [7:0] wdata_in, // Write data
    input wire logic msg_pending_in, // Output buffer holds a message
    output logic [7:0] latch_out, // Event latch
    output logic [7:0] eve_out, // Event enable mask
    output logic [7:0] sve_out, // Service enable mask
    output logic [7:0] stb_out // Status byte, combinational
);
    logic esum;
    logic [7:0] stb_low;

    // Set wins over read-clear and clear status
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            latch_out <= 8'h00_00 | (8'h00_01 << EVT_POWER_BIT);
        end else if (clear_in || latch_read_in) begin
            latch_out <= event_set_in & EVT_USED_MASK;
        end else begin
            latch_out <= latch_out | (event_set_in & EVT_USED_MASK);
        end
    end

    // Masks survive clear status
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            eve_out <= MASK_RESET;
            sve_out <= MASK_RESET;
        end else begin
            if (eve_wr_in) begin
                eve_out <= wdata_in & EVT_USED_MASK;
            end
            if (sve_wr_in) begin
                sve_out <= wdata_in & SVC_USED_MASK;
            end
        end
    end

    // Summary bits recomputed live, never latched
    always_comb begin
        esum = |(latch_out & eve_out);
        stb_low = 8'h00_00;
        stb_low[STB_MSG_BIT] = msg_pending_in;
        stb_low[STB_ESUM_BIT] = esum;
        stb_out = stb_low;
        stb_out[STB_SSUM_BIT] = |(stb_low & sve_out);
    end
endmodule : srss_status_regs

/* File: srss_top.sv */
// Status reporting and save, recall and reset of instrument setpoints
`timescale 1ns/1ps
module srss_top
    import srss_pkg::*;
#(
    parameter logic [15:0] VOLT_MAX = 16'h00_FF, // Full scale voltage code
    parameter logic [15:0] CURR_MAX = 16'h00_FF, // Full scale current code
    parameter logic [7:0] MAKER_ID = 8'h00_A1, // Arbitrary maker code
    parameter logic [7:0] MODEL_ID = 8'h00_B2, // Arbitrary model code
    parameter logic [7:0] SERIAL_ID = 8'h00_5A // Arbitrary serial code
) (
    input wire logic clk_in, // Clock, 50 MHz
    input wire logic rst_in, // Sync reset, high
    input wire srss_cmd_t cmd_in, // Command pulse
    input wire logic [SLOT_AW-1:0] slot_in, // Slot index for store or restore
    input wire logic [SLOT_AW-1:0] last_slot_in, // Slot in use before turn-off
    input wire srss_setpts_t live_in, // Present setpoints for store
    input wire logic [7:0] event_set_in, // Event pulses, latch layout
    input wire logic msg_pending_in, // Output buffer holds a message
    input wire logic reg_rd_in, // Register read strobe
    input wire logic reg_wr_in, // Register write strobe
    input wire logic [1:0] reg_sel_in, // Register selector
    input wire logic [7:0] reg_wdata_in, // Register write data
    input wire logic [1:0] id_field_in, // Identity field number
    output logic [7:0] reg_rdata_out, // Register read data
    output logic reg_rvalid_out, // Read data valid pulse
    output logic [7:0] stb_out, // Live status byte
    output logic srq_out, // Service request level
    output logic [7:0] id_char_out, // Identity field token
    output srss_setpts_t set_out, // Applied setpoints
    output logic [15:0] volt_trig_out, // Triggered voltage setpoint
    output logic [15:0] curr_trig_out, // Triggered current setpoint
    output logic output_on_state_out, // Output enable state
    output logic continuous_arming_out, // Continuous arming
    output logic trig_cancel_out, // Abort pulse to trigger logic
    output logic busy_out, // Restore in progress
    output logic slot_fault_out // Last store or restore index invalid
);
    ////////////////////////////////////////////////////////////////////////
    // Restore sequencer
    typedef enum logic [1:0] {
        SRSS_IDLE,
        SRSS_READ,
        SRSS_LOAD
    } srss_state_t;

    srss_state_t state;
    srss_state_t next_state;
    logic [SLOT_AW-1:0] mem_addr;
    logic [SLOT_AW-1:0] load_addr;
    logic mem_wr;
    srss_setpts_t mem_rd;
    logic boot_pending;
    logic latch_read;
    logic clear_cmd;
    logic abort_now;
    logic slot_ok;
    logic [7:0] latch;
    logic [7:0] eve;
    logic [7:0] sve;
    logic [7:0] stb;
    logic [7:0] next_rdata;

    // Scale a full scale code to 110 percent, saturating at the code range
    function automatic logic [15:0] prot_default(input logic [15:0] full);
        logic [31:0] wide;
        wide = (32'(full) * 32'(PROT_PCT)) / 32'(PCT_DIV);
        prot_default = (wide > 32'h0000_FFFF) ? 16'hFFFF : wide[15:0];
    endfunction : prot_default

    function automatic logic valid_slot(input logic [SLOT_AW-1:0] idx);
        valid_slot = 32'(idx) < SLOT_COUNT;
    endfunction : valid_slot

    assign slot_ok = valid_slot(slot_in);
    assign latch_read = reg_rd_in && (reg_sel_in == REG_EVENT_LATCH);
    assign clear_cmd = (cmd_in == SRSS_CMD_CLEAR);
    // Restore forces the abort two cycles before its reload, factory reset in the same cycle as its values
    assign abort_now = (cmd_in == SRSS_CMD_ABORT) || (cmd_in == SRSS_CMD_FACTORY)
        || (cmd_in == SRSS_CMD_RESTORE && slot_ok && state == SRSS_IDLE);
    assign mem_wr = (cmd_in == SRSS_CMD_STORE) && slot_ok && state == SRSS_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // Status registers and slot memory
    srss_status_regs i_srss_status_regs (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .event_set_in(event_set_in),
        .clear_in(clear_cmd),
        .latch_read_in(latch_read),
        .eve_wr_in(reg_wr_in && reg_sel_in == REG_EVENT_ENABLE),
        .sve_wr_in(reg_wr_in && reg_sel_in == REG_SERVICE_ENABLE),
        .wdata_in(reg_wdata_in),
        .msg_pending_in(msg_pending_in && !clear_cmd),
        .latch_out(latch),
        .eve_out(eve),
        .sve_out(sve),
        .stb_out(stb)
    );

    srss_slot_mem i_srss_slot_mem (
        .clk_in(clk_in),
        .wr_en_in(mem_wr),
        .addr_in(mem_addr),
        .wr_data_in(live_in),
        .rd_data_out(mem_rd)
    );

    // Boot restore uses the saved index, otherwise the host index
    // Index held through a restore; the host may move slot_in once taken
    always_comb begin
        mem_addr = load_addr;
        if (state == SRSS_IDLE) begin
            mem_addr = boot_pending ? last_slot_in : slot_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read port; status byte read has no side effect
    always_comb begin
        next_rdata = 8'h00_00;
        unique case (reg_sel_in)
            REG_EVENT_LATCH: next_rdata = latch;
            REG_EVENT_ENABLE: next_rdata = eve;
            REG_STATUS_BYTE: next_rdata = stb;
            REG_SERVICE_ENABLE: next_rdata = sve;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00_00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // Live status byte and service request copied into flops
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stb_out <= 8'h00_00;
            srq_out <= 1'b0;
        end else begin
            stb_out <= stb;
            srq_out <= stb[STB_SSUM_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Identity tokens: maker code, model code, serial; field 3 gives the comma separator
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            id_char_out <= 8'h00_00;
        end else begin
            unique case (id_field_in)
                2'h0: id_char_out <= MAKER_ID;
                2'h1: id_char_out <= MODEL_ID;
                2'h2: id_char_out <= SERIAL_ID;
                2'h3: id_char_out <= 8'h00_2C;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: one cycle in SRSS_READ for memory read latency before loading
    always_comb begin
        next_state = state;
        unique case (state)
            SRSS_IDLE: begin
                if (boot_pending || (cmd_in == SRSS_CMD_RESTORE && slot_ok)) begin
                    next_state = SRSS_READ;
                end
            end
            SRSS_READ: next_state = SRSS_LOAD;
            SRSS_LOAD: next_state = SRSS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= SRSS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Boot restore is requested once after every reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            boot_pending <= 1'b1;
        end else if (state == SRSS_IDLE) begin
            boot_pending <= 1'b0;
        end
    end

    // Capture the reload index in the cycle the restore is taken
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            load_addr <= '0;
        end else if (state == SRSS_IDLE) begin
            load_addr <= mem_addr;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            slot_fault_out <= 1'b0;
        end else begin
            busy_out <= (next_state != SRSS_IDLE);
            if (cmd_in == SRSS_CMD_STORE || cmd_in == SRSS_CMD_RESTORE) begin
                slot_fault_out <= !slot_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger abort and arming
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trig_cancel_out <= 1'b0;
            continuous_arming_out <= 1'b0;
        end else begin
            trig_cancel_out <= abort_now;
            if (abort_now) begin
                continuous_arming_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Applied setpoints: factory reset or reload from slot
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            set_out <= '0;
            volt_trig_out <= 16'h0000;
            curr_trig_out <= 16'h0000;
            output_on_state_out <= 1'b0;
        end else if (cmd_in == SRSS_CMD_FACTORY) begin
            set_out.volt <= 16'h0000;
            set_out.curr <= 16'h0000;
            set_out.timed_run <= 16'h0000;
            set_out.volt_prot <= prot_default(VOLT_MAX);
            set_out.curr_prot <= prot_default(CURR_MAX);
            volt_trig_out <= 16'h0000;
            curr_trig_out <= 16'h0000;
            output_on_state_out <= 1'b0;
        end else if (state == SRSS_LOAD) begin
            set_out <= mem_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_restore_req;
        cmd_in == SRSS_CMD_RESTORE && slot_ok && state == SRSS_IDLE && !boot_pending;
    endsequence

    sequence s_abort_then_load;
        trig_cancel_out && !continuous_arming_out ##1 state == SRSS_LOAD;
    endsequence

    property p_restore_aborts;
        @(posedge clk_in) disable iff (rst_in)
        s_restore_req |=> s_abort_then_load;
    endproperty
    a_restore_aborts: assert property (p_restore_aborts)
        else $error("restore did not abort before reload");

    property p_ssum;
        @(posedge clk_in) disable iff (rst_in)
        stb[STB_SSUM_BIT] == |(stb & sve & SVC_USED_MASK);
    endproperty
    a_ssum: assert property (p_ssum)
        else $error("service summary mismatch");

    property p_srq_zero_mask;
        @(posedge clk_in) disable iff (rst_in)
        sve == 8'h00_00 |=> !srq_out;
    endproperty
    a_srq_zero_mask: assert property (p_srq_zero_mask)
        else $error("service request with zero mask");

    property p_esum;
        @(posedge clk_in) disable iff (rst_in)
        stb[STB_ESUM_BIT] == (|(latch & eve));
    endproperty
    a_esum: assert property (p_esum)
        else $error("event summary mismatch");

    property p_latch_clear;
        @(posedge clk_in) disable iff (rst_in)
        latch_read && event_set_in == 8'h00_00 |=> latch == 8'h00_00 && reg_rdata_out == $past(latch);
    endproperty
    a_latch_clear: assert property (p_latch_clear)
        else $error("event latch not cleared by read");

    property p_power_event;
        @(posedge clk_in)
        rst_in |=> latch[EVT_POWER_BIT];
    endproperty
    a_power_event: assert property (p_power_event)
        else $error("power-up event missing after reset");

    property p_stb_read_keeps;
        @(posedge clk_in) disable iff (rst_in)
        reg_rd_in && reg_sel_in == REG_STATUS_BYTE && event_set_in == 8'h00_00 && !clear_cmd
        |=> latch == $past(latch);
    endproperty
    a_stb_read_keeps: assert property (p_stb_read_keeps)
        else $error("status byte read changed state");

    property p_factory;
        @(posedge clk_in) disable iff (rst_in)
        cmd_in == SRSS_CMD_FACTORY |=> !output_on_state_out && set_out.volt == 16'h0000
            && !continuous_arming_out && trig_cancel_out
            && set_out.volt_prot == prot_default(VOLT_MAX);
    endproperty
    a_factory: assert property (p_factory)
        else $error("factory reset values wrong");

    property p_sve_bits;
        @(posedge clk_in) disable iff (rst_in)
        (sve & ~SVC_USED_MASK) == 8'h00_00;
    endproperty
    a_sve_bits: assert property (p_sve_bits)
        else $error("unused service enable bit set");
endmodule : srss_top

/* File: test_status_reporting_and_state_store.sv */
// Self-checking bench for the status and state store block
`timescale 1ns/1ps
module test_status_reporting_and_state_store
    import srss_pkg::*;
;
    logic clk_in, rst_in, msg_pending, rd, wr, rvalid, srq, busy, fault, cancel, arming, out_on;
    logic [1:0] sel, id_field;
    logic [7:0] wdata, rdata, stb, events, id_char, d;
    logic [15:0] vtrig, ctrig;
    logic [SLOT_AW-1:0] slot, last_slot;
    srss_cmd_t cmd;
    srss_setpts_t live, set_now;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic ok;
    logic [15:0] prot;

    srss_top i_srss_top (.clk_in(clk_in), .rst_in(rst_in), .cmd_in(cmd), .slot_in(slot),
        .last_slot_in(last_slot), .live_in(live), .event_set_in(events),
        .msg_pending_in(msg_pending), .reg_rd_in(rd), .reg_wr_in(wr), .reg_sel_in(sel),
        .reg_wdata_in(wdata), .id_field_in(id_field), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .stb_out(stb), .srq_out(srq), .id_char_out(id_char),
        .set_out(set_now), .volt_trig_out(vtrig), .curr_trig_out(ctrig),
        .output_on_state_out(out_on), .continuous_arming_out(arming),
        .trig_cancel_out(cancel), .busy_out(busy), .slot_fault_out(fault));

    srss_host_model i_srss_host_model (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .rd_out(rd), .wr_out(wr), .sel_out(sel), .wdata_out(wdata), .cmd_out(cmd),
        .slot_out(slot));

    ////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock and a hang guard well above the expected run
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    // Verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string name, input logic [79:0] exp, input logic [79:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors = n_errors + 1;
        end
    endtask : chk

    // Register read through the host model, valid pulse checked alongside
    task automatic rchk(input string name, input logic [1:0] s, input logic [7:0] exp);
        i_srss_host_model.reg_read(s, d, ok);
        chk(name, {72'h0, exp}, {72'h0, d});
        chk("read valid", 80'h1, {79'h0, ok});
    endtask : rchk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : idle

    // Synchronous reset held for 16 cycles; boot restore then settles
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        idle(4);
    endtask : do_reset

    task automatic pulse_events(input logic [7:0] e);
        @(posedge clk_in);
        events <= e;
        @(posedge clk_in);
        events <= 8'h00;
        idle(3);
    endtask : pulse_events

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_in = 1'b1;
        msg_pending = 1'b0;
        events = 8'h00;
        id_field = 2'h0;
        last_slot = 7'h00;
        live = 80'h1111_2222_3333_4444_5555;
        prot = 16'((16'h00FF * PROT_PCT) / PCT_DIV);
        do_reset();
        rchk("latch after reset", REG_EVENT_LATCH, 8'h80);
        rchk("latch after read", REG_EVENT_LATCH, 8'h00);
        chk("stb after reset", 80'h0, {72'h0, stb});
        pulse_events(8'hFF);
        rchk("latch layout", REG_EVENT_LATCH, 8'hBD);
        i_srss_host_model.reg_write(REG_EVENT_ENABLE, 8'hFF);
        rchk("event enable", REG_EVENT_ENABLE, 8'hBD);
        i_srss_host_model.reg_write(REG_SERVICE_ENABLE, 8'hFF);
        rchk("service enable", REG_SERVICE_ENABLE, 8'h30);
        // Command fault event sets the event summary, which requests service
        pulse_events(8'h20);
        chk("stb event summary", {72'h0, 8'h60}, {72'h0, stb});
        chk("srq event summary", 80'h1, {79'h0, srq});
        rchk("stb read one", REG_STATUS_BYTE, 8'h60);
        rchk("stb read two", REG_STATUS_BYTE, 8'h60);
        msg_pending <= 1'b1;
        idle(3);
        chk("stb message", {72'h0, 8'h70}, {72'h0, stb});
        i_srss_host_model.reg_write(REG_SERVICE_ENABLE, 8'h00);
        idle(3);
        chk("srq masked", 80'h0, {79'h0, srq});
        chk("stb masked", {72'h0, 8'h30}, {72'h0, stb});
        i_srss_host_model.reg_write(REG_SERVICE_ENABLE, 8'h10);
        idle(3);
        chk("stb message only", {72'h0, 8'h70}, {72'h0, stb});
        i_srss_host_model.command(SRSS_CMD_CLEAR, 7'h00);
        chk("message bit on clear", 80'h0, {79'h0, stb[STB_MSG_BIT]});
        msg_pending <= 1'b0;
        idle(3);
        rchk("latch after clear", REG_EVENT_LATCH, 8'h00);
        rchk("enable after clear", REG_EVENT_ENABLE, 8'hBD);
        chk("stb after clear", 80'h0, {72'h0, stb});
        // Store into the last slot, refuse one past it, restore the last slot
        i_srss_host_model.command(SRSS_CMD_STORE, 7'd99);
        chk("fault valid slot", 80'h0, {79'h0, fault});
        i_srss_host_model.command(SRSS_CMD_STORE, 7'd100);
        chk("fault slot 100", 80'h1, {79'h0, fault});
        i_srss_host_model.command(SRSS_CMD_RESTORE, 7'd99);
        chk("restore cancel", 80'h1, {79'h0, cancel});
        chk("restore arming", 80'h0, {79'h0, arming});
        chk("restore busy", 80'h1, {79'h0, busy});
        idle(2);
        chk("restore data", live, set_now);
        chk("restore done", 80'h0, {79'h0, busy});
        i_srss_host_model.command(SRSS_CMD_FACTORY, 7'h00);
        chk("factory cancel", 80'h1, {79'h0, cancel});
        chk("factory set", {32'h0, prot, prot, 16'h0}, set_now);
        chk("factory trig", 80'h0, {48'h0, vtrig, ctrig});
        chk("factory output", 80'h0, {78'h0, out_on, arming});
        // Boot restore reloads the slot in use before the reset
        live <= 80'hA5A5_0102_0304_0506_0708;
        i_srss_host_model.command(SRSS_CMD_STORE, 7'd5);
        last_slot <= 7'd5;
        do_reset();
        chk("boot restore", 80'hA5A5_0102_0304_0506_0708, set_now);
        rchk("latch second reset", REG_EVENT_LATCH, 8'h80);
        id_field <= 2'h3;
        idle(3);
        chk("identity separator", {72'h0, 8'h2C}, {72'h0, id_char});
        close_out();
    end
endmodule : test_status_reporting_and_state_store
